// >>> core/fault_sleep_params.svh
`ifndef FAULT_SLEEP_PARAMS_SVH
`define FAULT_SLEEP_PARAMS_SVH

// ==========================================
// Widths
`define PRIO_W 3
`define ADDR_W 32

// ==========================================
// Reset values
`define ADDR_RST 32'h0000_0000
`define BIT_RST 1'b0

`endif

// >>> core/fault_sleep_pkg.sv
package fault_sleep_pkg;

  // ==========================================
  // Cause flags per fault class
  typedef struct packed {
    logic vector_read_fault_flag;
    logic escalation_indication_flag;
  } hard_st_s;

  typedef struct packed {
    logic instr_access_violation_flag;
    logic data_access_violation_flag;
    logic mem_push_violation_flag;
    logic mem_pop_violation_flag;
  } mem_st_s;

  typedef struct packed {
    logic bus_push_error_flag;
    logic bus_pop_error_flag;
    logic prefetch_bus_error_flag;
    logic exact_data_bus_error_flag;
    logic inexact_data_bus_error_flag;
  } bus_st_s;

  typedef struct packed {
    logic coprocessor_access_flag;
    logic undefined_opcode_flag;
    logic bad_execution_state_flag;
    logic bad_return_value_flag;
    logic misaligned_access_flag;
    logic zero_divisor_flag;
  } use_st_s;

  // ==========================================
  // Sleep states
  typedef enum logic [1:0] {
    PWR_RUN = 2'b00,
    PWR_IRQ_SLEEP = 2'b01,
    PWR_EVT_SLEEP = 2'b10
  } pwr_e;

endpackage

// >>> core/fault_escalation_sleep_control.sv
`timescale 1ns/1ps
`include "fault_sleep_params.svh"

module fault_escalation_sleep_control (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic vec_read_err_i,
  input wire logic no_exec_fetch_i,
  input wire fault_sleep_pkg::mem_st_s mem_ev_i,
  input wire fault_sleep_pkg::bus_st_s bus_ev_i,
  input wire fault_sleep_pkg::use_st_s use_ev_i,
  input wire logic [`ADDR_W-1:0] fault_addr_i,
  input wire logic mem_en_i,
  input wire logic bus_en_i,
  input wire logic use_en_i,
  input wire logic [`PRIO_W-1:0] mem_prio_i,
  input wire logic [`PRIO_W-1:0] bus_prio_i,
  input wire logic [`PRIO_W-1:0] use_prio_i,
  input wire logic handler_mode_i,
  input wire logic [`PRIO_W-1:0] cur_prio_i,
  input wire logic in_nmi_i,
  input wire logic in_hard_i,
  input wire logic bus_entry_i,
  input wire logic nmi_i,
  input wire fault_sleep_pkg::hard_st_s hard_clear_i,
  input wire fault_sleep_pkg::mem_st_s mem_clear_i,
  input wire fault_sleep_pkg::bus_st_s bus_clear_i,
  input wire fault_sleep_pkg::use_st_s use_clear_i,
  input wire logic wait_interrupt_instr_i,
  input wire logic wait_event_instr_i,
  input wire logic send_event_instr_i,
  input wire logic ext_event_i,
  input wire logic exit_to_thread_i,
  input wire logic deep_sleep_select_bit_i,
  input wire logic sleep_after_handler_bit_i,
  input wire logic event_on_pending_bit_i,
  input wire logic priority_mask_bit_i,
  input wire logic fault_mask_bit_i,
  input wire logic exc_sufficient_i,
  input wire logic irq_above_cur_i,
  input wire logic irq_new_pend_i,
  output logic take_hard_o,
  output logic take_mem_o,
  output logic take_bus_o,
  output logic take_use_o,
  output fault_sleep_pkg::hard_st_s hard_fault_status_reg_o,
  output fault_sleep_pkg::mem_st_s mem_manage_status_reg_o,
  output fault_sleep_pkg::bus_st_s bus_fault_status_reg_o,
  output fault_sleep_pkg::use_st_s usage_fault_status_reg_o,
  output logic [`ADDR_W-1:0] mem_manage_address_reg_o,
  output logic [`ADDR_W-1:0] bus_fault_address_reg_o,
  output logic lockup_o,
  output logic sleep_o,
  output logic deep_sleep_o,
  output logic wake_o
);

  // ==========================================
  // Escalation decision
  function automatic logic esc_f(
    input logic en,
    input logic [`PRIO_W-1:0] prio,
    input logic hmode,
    input logic [`PRIO_W-1:0] cur,
    input logic fixed
  );
    esc_f = !en | fixed | (hmode & (prio >= cur));
  endfunction

  fault_sleep_pkg::pwr_e state;
  fault_sleep_pkg::pwr_e next_state;
  logic lock_from_nmi;
  logic event_latch;
  logic mem_any;
  logic bus_any;
  logic use_any;
  logic above_all;
  logic bus_keep;
  logic mem_esc;
  logic bus_esc;
  logic use_esc;
  logic any_esc;
  logic hard_req;
  logic go_lock;
  logic ev_set;
  logic ev_take;
  logic irq_wake;

  // ==========================================
  // Fault classification
  // no-execute fetch
  assign mem_any = no_exec_fetch_i | (|mem_ev_i);
  assign bus_any = |bus_ev_i;
  assign use_any = |use_ev_i;
  assign above_all = in_nmi_i | in_hard_i;
  assign bus_keep = bus_ev_i.bus_push_error_flag & bus_entry_i;
  assign mem_esc = mem_any & esc_f(mem_en_i, mem_prio_i, handler_mode_i, cur_prio_i, above_all);
  assign bus_esc = bus_any & !bus_keep
    & esc_f(bus_en_i, bus_prio_i, handler_mode_i, cur_prio_i, above_all);
  assign use_esc = use_any & esc_f(use_en_i, use_prio_i, handler_mode_i, cur_prio_i, above_all);
  assign any_esc = mem_esc | bus_esc | use_esc;
  assign hard_req = vec_read_err_i | any_esc;
  assign go_lock = hard_req & above_all & !lockup_o;

  // ==========================================
  // Handler requests
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      take_hard_o <= `BIT_RST;
      take_mem_o <= `BIT_RST;
      take_bus_o <= `BIT_RST;
      take_use_o <= `BIT_RST;
    end else begin
      take_hard_o <= hard_req & !above_all & !lockup_o;
      take_mem_o <= mem_any & !mem_esc & !lockup_o;
      take_bus_o <= bus_any & !bus_esc & !lockup_o;
      take_use_o <= use_any & !use_esc & !lockup_o;
    end
  end

  // ==========================================
  // Status flags, set wins over clear
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      hard_fault_status_reg_o <= '0;
    end else begin
      hard_fault_status_reg_o.vector_read_fault_flag <= vec_read_err_i
        | (hard_fault_status_reg_o.vector_read_fault_flag
           & !hard_clear_i.vector_read_fault_flag);
      hard_fault_status_reg_o.escalation_indication_flag <= any_esc
        | (hard_fault_status_reg_o.escalation_indication_flag
           & !hard_clear_i.escalation_indication_flag);
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mem_manage_status_reg_o <= '0;
    end else begin
      mem_manage_status_reg_o <= (mem_manage_status_reg_o & ~mem_clear_i) | mem_ev_i
        | {no_exec_fetch_i, 3'b000};
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      bus_fault_status_reg_o <= '0;
    end else begin
      bus_fault_status_reg_o <= (bus_fault_status_reg_o & ~bus_clear_i) | bus_ev_i;
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      usage_fault_status_reg_o <= '0;
    end else begin
      usage_fault_status_reg_o <= (usage_fault_status_reg_o & ~use_clear_i) | use_ev_i;
    end
  end

  // ==========================================
  // Fault address capture
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mem_manage_address_reg_o <= `ADDR_RST;
      bus_fault_address_reg_o <= `ADDR_RST;
    end else begin
      if (no_exec_fetch_i | mem_ev_i.instr_access_violation_flag
          | mem_ev_i.data_access_violation_flag) begin
        mem_manage_address_reg_o <= fault_addr_i;
      end
      if (bus_ev_i.exact_data_bus_error_flag | bus_ev_i.prefetch_bus_error_flag) begin
        bus_fault_address_reg_o <= fault_addr_i;
      end
    end
  end

  // ==========================================
  // Lockup
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      lockup_o <= `BIT_RST;
      lock_from_nmi <= `BIT_RST;
    end else if (go_lock) begin
      lockup_o <= 1'b1;
      lock_from_nmi <= in_nmi_i;
    end else if (lockup_o & nmi_i & !lock_from_nmi) begin
      lockup_o <= `BIT_RST;
    end
  end

  // ==========================================
  // Event latch
  // other processor event
  assign ev_set = ext_event_i | send_event_instr_i
    | (event_on_pending_bit_i & irq_new_pend_i);
  assign ev_take = event_latch
    & (((state == fault_sleep_pkg::PWR_RUN) & wait_event_instr_i & !lockup_o)
       | (state == fault_sleep_pkg::PWR_EVT_SLEEP));

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      event_latch <= `BIT_RST;
    end else begin
      event_latch <= ev_set | (event_latch & !ev_take);
    end
  end

  // ==========================================
  // Sleep state machine
  // sufficient exception wakes
  assign irq_wake = exc_sufficient_i
    | (irq_above_cur_i & priority_mask_bit_i & !fault_mask_bit_i);

  always_comb begin
    next_state = state;
    unique case (state)
      fault_sleep_pkg::PWR_RUN: begin
        if (lockup_o) begin
          next_state = fault_sleep_pkg::PWR_RUN;
        end else if (wait_interrupt_instr_i) begin
          next_state = fault_sleep_pkg::PWR_IRQ_SLEEP;
        end else if (wait_event_instr_i & !event_latch) begin
          next_state = fault_sleep_pkg::PWR_EVT_SLEEP;
        end else if (exit_to_thread_i & sleep_after_handler_bit_i) begin
          next_state = fault_sleep_pkg::PWR_IRQ_SLEEP;
        end
      end
      fault_sleep_pkg::PWR_IRQ_SLEEP: begin
        if (irq_wake) begin
          next_state = fault_sleep_pkg::PWR_RUN;
        end
      end
      fault_sleep_pkg::PWR_EVT_SLEEP: begin
        if (irq_wake | event_latch) begin
          next_state = fault_sleep_pkg::PWR_RUN;
        end
      end
      default: begin
        next_state = fault_sleep_pkg::PWR_RUN;
      end
    endcase
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state <= fault_sleep_pkg::PWR_RUN;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sleep_o <= `BIT_RST;
      deep_sleep_o <= `BIT_RST;
      wake_o <= `BIT_RST;
    end else begin
      sleep_o <= next_state != fault_sleep_pkg::PWR_RUN;
      if (state == fault_sleep_pkg::PWR_RUN) begin
        deep_sleep_o <= (next_state != fault_sleep_pkg::PWR_RUN) & deep_sleep_select_bit_i;
      end else if (next_state == fault_sleep_pkg::PWR_RUN) begin
        deep_sleep_o <= `BIT_RST;
      end
      wake_o <= (state != fault_sleep_pkg::PWR_RUN) & (next_state == fault_sleep_pkg::PWR_RUN);
    end
  end

  // ==========================================
  // Checks
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!nrst_i);

  vec_flag_a:
    assert property (vec_read_err_i && !above_all && !lockup_o |=>
      take_hard_o && hard_fault_status_reg_o.vector_read_fault_flag)
    else $error("vector read error not handled as hard fault");

  escalate_flag_a:
    assert property (any_esc |=> hard_fault_status_reg_o.escalation_indication_flag)
    else $error("escalation flag not set");

  no_exec_a:
    assert property (no_exec_fetch_i && !lockup_o && mem_en_i && !handler_mode_i
      && !above_all |=> take_mem_o && mem_manage_status_reg_o.instr_access_violation_flag)
    else $error("no-execute fetch missed");

  disabled_a:
    assert property (use_any && !use_en_i && !above_all && !lockup_o |=>
      take_hard_o && !take_use_o)
    else $error("disabled usage fault not escalated");

  push_keep_a:
    assert property (bus_keep && !lockup_o |=> take_bus_o)
    else $error("push error on bus entry escalated");

  addr_cap_a:
    assert property (bus_ev_i.exact_data_bus_error_flag |=>
      bus_fault_address_reg_o == $past(fault_addr_i))
    else $error("bus fault address not captured");

  lock_in_a:
    assert property (hard_req && in_nmi_i && !lockup_o |=> lockup_o && !take_hard_o)
    else $error("nested hard fault did not lock up");

  lock_nmi_a:
    assert property (lockup_o && lock_from_nmi && !go_lock |=> lockup_o)
    else $error("lockup from NMI handler released");

  wfi_now_a:
    assert property (state == fault_sleep_pkg::PWR_RUN && wait_interrupt_instr_i
      && !lockup_o |=> sleep_o)
    else $error("wait for interrupt did not sleep");

  wfe_skip_a:
    assert property (state == fault_sleep_pkg::PWR_RUN && wait_event_instr_i
      && !wait_interrupt_instr_i && event_latch && !ev_set && !lockup_o
      && !(exit_to_thread_i && sleep_after_handler_bit_i) |=> !sleep_o && !event_latch)
    else $error("set event latch not consumed");

  pend_wake_a:
    assert property (state == fault_sleep_pkg::PWR_EVT_SLEEP && event_on_pending_bit_i
      && irq_new_pend_i |-> ##[1:2] state == fault_sleep_pkg::PWR_RUN)
    else $error("new pending interrupt did not wake");

endmodule

// >>> testbench/far_side_model.sv
`timescale 1ns/1ps

// ==========================================
// Interrupt controller and peer core model
module far_side_model (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic peer_event_i,
  input wire logic irq_req_i,
  input wire logic prio_ok_i,
  output logic ext_event_o,
  output logic irq_new_pend_o,
  output logic exc_sufficient_o
);
  logic pend;

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ext_event_o <= 1'h0;
    end else begin
      ext_event_o <= peer_event_i;
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pend <= 1'h0;
      irq_new_pend_o <= 1'h0;
      exc_sufficient_o <= 1'h0;
    end else begin
      pend <= irq_req_i;
      irq_new_pend_o <= irq_req_i & ~pend;
      exc_sufficient_o <= irq_req_i & prio_ok_i;
    end
  end
endmodule

// >>> testbench/fault_escalation_sleep_control_tb.sv
`timescale 1ns/1ps
`include "fault_sleep_params.svh"

module fault_escalation_sleep_control_tb;
  logic mclk_i = 1'h0, nrst_i = 1'h0, vec_read_err_i = 1'h0, no_exec_fetch_i = 1'h0;
  logic nmi_i = 1'h0, bus_entry_i = 1'h0, mem_en_i = 1'h1, bus_en_i = 1'h1, use_en_i = 1'h1;
  logic handler_mode_i = 1'h0, in_nmi_i = 1'h0, in_hard_i = 1'h0, wait_interrupt_instr_i = 1'h0;
  logic wait_event_instr_i = 1'h0, send_event_instr_i = 1'h0, exit_to_thread_i = 1'h0;
  logic deep_sleep_select_bit_i = 1'h0, sleep_after_handler_bit_i = 1'h0;
  logic event_on_pending_bit_i = 1'h0, priority_mask_bit_i = 1'h0, fault_mask_bit_i = 1'h0;
  logic irq_above_cur_i = 1'h0, peer_event = 1'h0, irq_req = 1'h0, prio_ok = 1'h0;
  logic ext_event_i, exc_sufficient_i, irq_new_pend_i;
  logic [`PRIO_W-1:0] mem_prio_i = 3'h4, bus_prio_i = 3'h4, use_prio_i = 3'h4, cur_prio_i = 3'h7;
  logic [`ADDR_W-1:0] fault_addr_i = 32'h0000_0000;
  fault_sleep_pkg::hard_st_s hard_clear_i = '0;
  fault_sleep_pkg::mem_st_s mem_ev_i = '0, mem_clear_i = '0;
  fault_sleep_pkg::bus_st_s bus_ev_i = '0, bus_clear_i = '0;
  fault_sleep_pkg::use_st_s use_ev_i = '0, use_clear_i = '0;
  logic take_hard_o, take_mem_o, take_bus_o, take_use_o, lockup_o, sleep_o, deep_sleep_o, wake_o;
  fault_sleep_pkg::hard_st_s hard_fault_status_reg_o;
  fault_sleep_pkg::mem_st_s mem_manage_status_reg_o;
  fault_sleep_pkg::bus_st_s bus_fault_status_reg_o;
  fault_sleep_pkg::use_st_s usage_fault_status_reg_o;
  logic [`ADDR_W-1:0] mem_manage_address_reg_o, bus_fault_address_reg_o;
  int fail_count = 0, total_checks = 0, cycles = 0;

  fault_escalation_sleep_control u_fault_escalation_sleep_control (
    .mclk_i, .nrst_i, .vec_read_err_i, .no_exec_fetch_i, .mem_ev_i, .bus_ev_i, .use_ev_i,
    .fault_addr_i, .mem_en_i, .bus_en_i, .use_en_i, .mem_prio_i, .bus_prio_i, .use_prio_i,
    .handler_mode_i, .cur_prio_i, .in_nmi_i, .in_hard_i, .bus_entry_i, .nmi_i, .hard_clear_i,
    .mem_clear_i, .bus_clear_i, .use_clear_i, .wait_interrupt_instr_i, .wait_event_instr_i,
    .send_event_instr_i, .ext_event_i, .exit_to_thread_i, .deep_sleep_select_bit_i,
    .sleep_after_handler_bit_i, .event_on_pending_bit_i, .priority_mask_bit_i,
    .fault_mask_bit_i, .exc_sufficient_i, .irq_above_cur_i, .irq_new_pend_i, .take_hard_o,
    .take_mem_o, .take_bus_o, .take_use_o, .hard_fault_status_reg_o, .mem_manage_status_reg_o,
    .bus_fault_status_reg_o, .usage_fault_status_reg_o, .mem_manage_address_reg_o,
    .bus_fault_address_reg_o, .lockup_o, .sleep_o, .deep_sleep_o, .wake_o
  );

  far_side_model u_far_side_model (
    .mclk_i, .nrst_i, .peer_event_i(peer_event), .irq_req_i(irq_req), .prio_ok_i(prio_ok),
    .ext_event_o(ext_event_i), .irq_new_pend_o(irq_new_pend_i),
    .exc_sufficient_o(exc_sufficient_i)
  );

  always #5 mclk_i = ~mclk_i;

  // ==========================================
  // Shared tasks
  task test_done;
    $display("checks=%0d mismatches=%0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task do_reset(input int n);
    @(posedge mclk_i);
    nrst_i <= 1'h0;
    repeat (n) @(posedge mclk_i);
    nrst_i <= 1'h1;
    @(posedge mclk_i);
  endtask

  task tick;
    @(posedge mclk_i);
    {vec_read_err_i, no_exec_fetch_i, nmi_i, wait_interrupt_instr_i, peer_event} <= '0;
    {wait_event_instr_i, send_event_instr_i, exit_to_thread_i} <= '0;
    mem_ev_i <= '0;
    bus_ev_i <= '0;
    use_ev_i <= '0;
    hard_clear_i <= '0;
    use_clear_i <= '0;
    mem_clear_i <= '0;
    bus_clear_i <= '0;
    #1;
  endtask

  task wait_wake(input int n);
    int k;
    k = 0;
    while (wake_o !== 1'h1 && k < n) begin
      @(posedge mclk_i);
      #1;
      k++;
    end
    chk(wake_o, 1'h1);
    chk(sleep_o, 1'h0);
  endtask

  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      test_done;
    end
  end

  // ==========================================
  // Test sequence
  initial begin
    do_reset(20);
    @(posedge mclk_i);
    no_exec_fetch_i <= 1'h1;
    fault_addr_i <= 32'h2000_0000;
    tick;
    chk(take_mem_o, 1'h1);
    chk(mem_manage_status_reg_o, 4'h8);
    chk(mem_manage_address_reg_o, 32'h2000_0000);
    for (int i = 0; i < 4; i++) begin
      @(posedge mclk_i);
      mem_ev_i <= 4'h1 << i;
      fault_addr_i <= 32'h1000_0000 + i;
      tick;
      chk(take_mem_o, 1'h1);
    end
    chk(mem_manage_address_reg_o, 32'h1000_0003);
    @(posedge mclk_i);
    mem_clear_i <= 4'hf;
    mem_ev_i <= 4'h1;
    tick;
    chk(mem_manage_status_reg_o, 4'h1);
    for (int i = 0; i < 5; i++) begin
      @(posedge mclk_i);
      bus_ev_i <= 5'h01 << i;
      fault_addr_i <= 32'h3000_0000 + i;
      tick;
      chk(take_bus_o, 1'h1);
      chk(bus_fault_status_reg_o, (32'h1 << (i + 1)) - 1);
    end
    chk(bus_fault_address_reg_o, 32'h3000_0002);
    @(posedge mclk_i);
    bus_clear_i <= 5'h1f;
    tick;
    chk(bus_fault_status_reg_o, 5'h00);
    chk(mem_manage_address_reg_o, 32'h1000_0003);
    for (int i = 0; i < 6; i++) begin
      @(posedge mclk_i);
      use_ev_i <= 6'h01 << i;
      tick;
      chk(take_use_o, 1'h1);
      chk(take_hard_o, 1'h0);
      chk(usage_fault_status_reg_o, (32'h1 << (i + 1)) - 1);
    end
    @(posedge mclk_i);
    use_clear_i <= 6'h3f;
    tick;
    chk(usage_fault_status_reg_o, 6'h00);
    @(posedge mclk_i);
    use_en_i <= 1'h0;
    use_ev_i <= 6'h01;
    tick;
    chk(take_hard_o, 1'h1);
    chk(take_use_o, 1'h0);
    chk(hard_fault_status_reg_o, 2'h1);
    chk(usage_fault_status_reg_o, 6'h01);
    @(posedge mclk_i);
    hard_clear_i <= 2'h1;
    use_en_i <= 1'h1;
    tick;
    chk(hard_fault_status_reg_o, 2'h0);
    @(posedge mclk_i);
    bus_en_i <= 1'h0;
    bus_ev_i <= 5'h02;
    tick;
    chk(take_hard_o, 1'h1);
    chk(take_bus_o, 1'h0);
    @(posedge mclk_i);
    hard_clear_i <= 2'h1;
    bus_en_i <= 1'h1;
    handler_mode_i <= 1'h1;
    cur_prio_i <= 3'h2;
    use_prio_i <= 3'h2;
    tick;
    @(posedge mclk_i);
    use_ev_i <= 6'h02;
    tick;
    chk(take_hard_o, 1'h1);
    chk(take_use_o, 1'h0);
    chk(hard_fault_status_reg_o, 2'h1);
    @(posedge mclk_i);
    use_prio_i <= 3'h1;
    use_ev_i <= 6'h02;
    tick;
    chk(take_use_o, 1'h1);
    chk(take_hard_o, 1'h0);
    @(posedge mclk_i);
    bus_prio_i <= 3'h5;
    bus_entry_i <= 1'h1;
    bus_ev_i <= 5'h10;
    tick;
    chk(take_bus_o, 1'h1);
    chk(take_hard_o, 1'h0);
    @(posedge mclk_i);
    bus_entry_i <= 1'h0;
    cur_prio_i <= 3'h0;
    vec_read_err_i <= 1'h1;
    tick;
    chk(take_hard_o, 1'h1);
    chk(hard_fault_status_reg_o, 2'h3);
    // ==========================================
    // Sleep and wakeup
    @(posedge mclk_i);
    handler_mode_i <= 1'h0;
    deep_sleep_select_bit_i <= 1'h1;
    wait_interrupt_instr_i <= 1'h1;
    tick;
    chk(sleep_o, 1'h1);
    chk(deep_sleep_o, 1'h1);
    @(posedge mclk_i);
    irq_req <= 1'h1;
    repeat (3) @(posedge mclk_i);
    #1;
    chk(sleep_o, 1'h1);
    @(posedge mclk_i);
    prio_ok <= 1'h1;
    wait_wake(8);
    @(posedge mclk_i);
    irq_req <= 1'h0;
    deep_sleep_select_bit_i <= 1'h0;
    wait_interrupt_instr_i <= 1'h1;
    tick;
    chk(sleep_o, 1'h1);
    chk(deep_sleep_o, 1'h0);
    @(posedge mclk_i);
    priority_mask_bit_i <= 1'h1;
    irq_above_cur_i <= 1'h1;
    wait_wake(8);
    @(posedge mclk_i);
    priority_mask_bit_i <= 1'h0;
    irq_above_cur_i <= 1'h0;
    send_event_instr_i <= 1'h1;
    tick;
    @(posedge mclk_i);
    wait_event_instr_i <= 1'h1;
    tick;
    chk(sleep_o, 1'h0);
    @(posedge mclk_i);
    wait_event_instr_i <= 1'h1;
    tick;
    chk(sleep_o, 1'h1);
    @(posedge mclk_i);
    peer_event <= 1'h1;
    tick;
    wait_wake(8);
    @(posedge mclk_i);
    sleep_after_handler_bit_i <= 1'h1;
    exit_to_thread_i <= 1'h1;
    tick;
    chk(sleep_o, 1'h1);
    @(posedge mclk_i);
    irq_req <= 1'h1;
    wait_wake(8);
    @(posedge mclk_i);
    irq_req <= 1'h0;
    sleep_after_handler_bit_i <= 1'h0;
    event_on_pending_bit_i <= 1'h1;
    prio_ok <= 1'h0;
    wait_event_instr_i <= 1'h1;
    tick;
    chk(sleep_o, 1'h1);
    @(posedge mclk_i);
    irq_req <= 1'h1;
    wait_wake(8);
    @(posedge mclk_i);
    irq_req <= 1'h0;
    // ==========================================
    // Lockup
    do_reset(2);
    in_nmi_i <= 1'h1;
    @(posedge mclk_i);
    vec_read_err_i <= 1'h1;
    tick;
    chk(lockup_o, 1'h1);
    @(posedge mclk_i);
    nmi_i <= 1'h1;
    tick;
    chk(lockup_o, 1'h1);
    do_reset(2);
    in_nmi_i <= 1'h0;
    in_hard_i <= 1'h1;
    @(posedge mclk_i);
    vec_read_err_i <= 1'h1;
    tick;
    chk(lockup_o, 1'h1);
    @(posedge mclk_i);
    nmi_i <= 1'h1;
    tick;
    chk(lockup_o, 1'h0);
    test_done;
  end
endmodule
